// File: core/lntc_pkg.sv
// constants and types shared by the transceiver mode control block
package lntc_pkg;

  // transceiver mode field codes
  typedef enum logic [1:0]
  {
    LM_OFF = 2'b00,
    LM_WAKE = 2'b01,
    LM_RXONLY = 2'b10,
    LM_NORMAL = 2'b11
  } lntc_mode_e;

  // device operating modes as reported by the mode controller
  typedef enum logic [2:0]
  {
    DM_NORMAL = 3'h0,
    DM_STOP = 3'h1,
    DM_SLEEP = 3'h2,
    DM_RESTART = 3'h3,
    DM_FAILSAFE = 3'h4
  } lntc_dev_e;

  // bus wake qualifier, gray along the usual path
  typedef enum logic [1:0]
  {
    WS_IDLE = 2'b00,
    WS_ARMED = 2'b01,
    WS_DOM = 2'b11,
    WS_QUAL = 2'b10
  } lntc_wake_e;

  // reset values
  localparam lntc_mode_e MODE_RESET = LM_OFF;
  localparam logic LOW_SLOPE_RESET = 1'b0;
  localparam logic FLASH_RESET = 1'b0;

  // configuration word layout: {mode, low slope, flash}
  localparam int CFG_W = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_LSM_BIT = 1;
  localparam int CFG_FLASH_BIT = 0;

  // timing, in microseconds, and the clock rate
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned WAKE_DOM_US = 30;
  localparam int unsigned EN_TIME_US = 10;
  localparam int unsigned TX_TO_US = 20000;
  localparam int unsigned BUS_TO_US = 20000;
  localparam int unsigned WAKE_DOM_CYC = WAKE_DOM_US * CLK_MHZ;
  localparam int unsigned EN_TIME_CYC = EN_TIME_US * CLK_MHZ;
  localparam int unsigned TX_TO_CYC = TX_TO_US * CLK_MHZ;
  localparam int unsigned BUS_TO_CYC = BUS_TO_US * CLK_MHZ;

  // pin synchroniser bit positions
  localparam int PIN_N = 4;
  localparam int PIN_TX = 0;
  localparam int PIN_BUS = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_UV = 3;
  localparam logic [PIN_N-1:0] PIN_RESET = 4'h7;

endpackage

// File: core/lntc_dom_timer.sv
// saturating counter that measures how long a level has been held high
`timescale 1ns/1ns
`default_nettype none
module lntc_dom_timer
#(
  parameter int unsigned LIMIT = 750
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // level in, expiry out
  input wire logic level,
  output logic expired
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_q;

  assign expired = (cnt_q == LIM);

  // any low cycle restarts the measurement
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt_q <= '0;
    else if (!level)
      cnt_q <= '0;
    else if (!expired)
      cnt_q <= cnt_q + 1'b1;
  end

endmodule
`default_nettype wire

// File: core/lntc_cfg_buffer.sv
// two-entry buffer holding configuration words until chip select rises
`timescale 1ns/1ns
`default_nettype none
module lntc_cfg_buffer
#(
  parameter int WIDTH = 4
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] slot_q [2];
  logic [1:0] cnt_q;
  logic ready_q;
  wire push = inValid && ready_q;
  wire pop = outReady && (cnt_q != 2'd0);
  wire [1:0] cntNext = cnt_q + {1'b0, push} - {1'b0, pop};
  // write lands behind the head, or in the head slot when empty or after a pop
  wire [0:0] wrIdx = (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) ? 1'b0 : 1'b1;

  assign inReady = ready_q;
  assign outValid = (cnt_q != 2'd0);
  assign outData = slot_q[0];

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= 2'd0;
      ready_q <= 1'b1;
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end
    else
    begin
      cnt_q <= cntNext;
      ready_q <= (cntNext != 2'd2);
      if (pop)
        slot_q[0] <= slot_q[1];
      if (push)
        slot_q[wrIdx] <= inData;
    end
  end

endmodule
`default_nettype wire

// File: core/lntc_mode_ctrl.sv
// LIN transceiver mode, wake, time-out and slope control
`timescale 1ns/1ns
`default_nettype none
module lntc_mode_ctrl
  import lntc_pkg::*;
#(
  parameter int unsigned TX_TO_CYCLES = TX_TO_CYC,
  parameter int unsigned BUS_TO_CYCLES = BUS_TO_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration writes from the serial decoder
  input wire logic cfgValid,
  output logic cfgReady,
  input wire logic [1:0] cfgMode,
  input wire logic cfgLowSlope,
  input wire logic cfgFlash,
  input wire logic chipSelectN,
  // device mode and watchdog
  input wire lntc_dev_e devMode,
  input wire logic watchdogOnBusWake,
  input wire logic watchdogEnabled,
  output logic restartReq,
  output logic watchdogEnableReq,
  // microcontroller pins
  input wire logic linTxInput,
  output logic linRxOutput,
  output logic interruptOutN,
  // bus side
  input wire logic busLevel,
  input wire logic busSupplyLow,
  output logic busDriveDominant,
  output logic lowSlope,
  output logic flashMode,
  // status
  output logic [1:0] transceiverMode,
  output logic wakeStatus,
  input wire logic wakeStatusClr,
  output logic linFault,
  input wire logic linFaultClr
);

  // pin synchronisers
  logic [PIN_N-1:0] pinMeta_q;
  logic [PIN_N-1:0] pinSync_q;
  logic csPrev_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pinMeta_q <= PIN_RESET;
      pinSync_q <= PIN_RESET;
      csPrev_q <= 1'b1;
    end
    else
    begin
      pinMeta_q <= {busSupplyLow, chipSelectN, busLevel, linTxInput};
      pinSync_q <= pinMeta_q;
      csPrev_q <= pinSync_q[PIN_CS];
    end
  end

  wire txDom = !pinSync_q[PIN_TX];
  wire busDom = !pinSync_q[PIN_BUS];
  wire uvLow = pinSync_q[PIN_UV];
  wire csRise = pinSync_q[PIN_CS] && !csPrev_q;

  // configuration words wait here for the end of the frame
  logic bufValid;
  logic [CFG_W-1:0] bufData;
  wire [CFG_W-1:0] cfgWord = {cfgMode, cfgLowSlope, cfgFlash};

  lntc_cfg_buffer #(.WIDTH(CFG_W)) u_buf
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .inValid(cfgValid),
    .inReady(cfgReady),
    .inData(cfgWord),
    .outValid(bufValid),
    .outReady(csRise),
    .outData(bufData)
  );

  // device mode tracking
  lntc_dev_e devPrev_q;
  wire devChanged = (devMode != devPrev_q);
  wire inNormal = (devMode == DM_NORMAL);
  wire inStop = (devMode == DM_STOP);
  wire enterFs = devChanged && (devMode == DM_FAILSAFE);
  wire rearm = devChanged && (inStop || devMode == DM_SLEEP ||
    devMode == DM_FAILSAFE);

  // mode request legality per device mode
  wire applyCfg = csRise && bufValid;
  wire [1:0] reqMode = bufData[CFG_MODE_LSB +: 2];
  wire commsOk = inNormal || inStop;
  wire wakeOk = commsOk || devMode == DM_SLEEP ||
    devMode == DM_RESTART;
  wire reqLegal = (reqMode == LM_OFF) ||
    ((reqMode == LM_NORMAL || reqMode == LM_RXONLY) && commsOk) ||
    ((reqMode == LM_WAKE) && wakeOk);

  lntc_mode_e mode_q;
  lntc_mode_e mode_d;
  always_comb
  begin
    mode_d = mode_q;
    if (enterFs)
      mode_d = LM_WAKE;
    else if (applyCfg && reqLegal)
      mode_d = lntc_mode_e'(reqMode);
  end
  wire modeChange = (mode_d != mode_q);

  // slope and flash only accepted while the device is in Normal
  logic lowSlope_q;
  logic flash_q;
  wire slopeWr = applyCfg && inNormal;

  // wake qualifier
  lntc_wake_e wState_q;
  lntc_wake_e wState_d;
  logic woke_q;
  logic wakeTimed;
  // off mode or a stale wake leaves the qualifier parked
  wire wakeRun = (mode_q == LM_WAKE) && !woke_q && !uvLow;

  lntc_dom_timer #(.LIMIT(WAKE_DOM_CYC)) u_wake_tmr
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .level(wState_q == WS_DOM && busDom),
    .expired(wakeTimed)
  );

  // requires recessive first so a bus already low at arming cannot wake
  always_comb
  begin
    wState_d = wState_q;
    if (!wakeRun)
      wState_d = WS_IDLE;
    else
      unique case (wState_q)
        WS_IDLE:
          if (!busDom)
            wState_d = WS_ARMED;
        WS_ARMED:
          if (busDom)
            wState_d = WS_DOM;
        WS_DOM:
          if (!busDom)
            wState_d = WS_ARMED;
          else if (wakeTimed)
            wState_d = WS_QUAL;
        WS_QUAL:
          if (!busDom)
            wState_d = WS_IDLE;
      endcase
  end
  wire wakeEvt = wakeRun && wState_q == WS_QUAL && !busDom;

  // woken flag: set wins over the clearing mode toggle or re-arm
  wire woke_d = wakeEvt || (woke_q && !modeChange && !rearm);

  // wake reaction per device mode
  wire wakeIrq = wakeEvt && commsOk;
  wire wakeRestart = wakeEvt && !commsOk;
  wire wdKick = wakeEvt && inStop && watchdogOnBusWake &&
    !watchdogEnabled;

  // enabling time after entering normal mode
  logic enDone;
  logic txGate_q;
  // undervoltage mutes the driver and the receiver; enabling state survives the dip
  wire normalOn = (mode_q == LM_NORMAL);

  lntc_dom_timer #(.LIMIT(EN_TIME_CYC)) u_en_tmr
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .level(normalOn),
    .expired(enDone)
  );

  // only a dominant starting after the enabling time passes
  wire txGate_d = normalOn && (txGate_q || (enDone && !txDom));

  // transmit dominant time-out, cleared by any recessive cycle
  logic txTimedOut;
  lntc_dom_timer #(.LIMIT(TX_TO_CYCLES)) u_tx_tmr
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .level(normalOn && txDom),
    .expired(txTimedOut)
  );

  // bus clamp watch while receiving
  logic busClamped;
  wire rxOn = (mode_q == LM_NORMAL || mode_q == LM_RXONLY) && !uvLow;
  lntc_dom_timer #(.LIMIT(BUS_TO_CYCLES)) u_bus_tmr
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .level(rxOn && busDom),
    .expired(busClamped)
  );

  // fault flag set once per time-out onset; set wins over clear
  logic txToPrev_q;
  logic clampPrev_q;
  wire faultSet = (txTimedOut && !txToPrev_q) ||
    (busClamped && !clampPrev_q);
  logic fault_q;
  wire fault_d = faultSet || (fault_q && !linFaultClr);

  // wake status sticky; set wins over clear
  logic wakeSt_q;
  wire wakeSt_d = wakeEvt || (wakeSt_q && !wakeStatusClr);
  logic intPend_q;
  wire intPend_d = wakeIrq || (intPend_q && !wakeStatusClr);

  // pin outputs
  wire drive_d = txGate_d && txDom && !txTimedOut &&
    !uvLow;
  wire rx_d = woke_d ? 1'b0 : (rxOn ? !busDom : 1'b1);

  logic drive_q;
  logic rx_q;
  logic restart_q;
  logic wdReq_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      devPrev_q <= DM_NORMAL;
      mode_q <= MODE_RESET;
      lowSlope_q <= LOW_SLOPE_RESET;
      flash_q <= FLASH_RESET;
      wState_q <= WS_IDLE;
      woke_q <= 1'b0;
      txGate_q <= 1'b0;
      txToPrev_q <= 1'b0;
      clampPrev_q <= 1'b0;
      fault_q <= 1'b0;
      wakeSt_q <= 1'b0;
      intPend_q <= 1'b0;
      drive_q <= 1'b0;
      rx_q <= 1'b1;
      restart_q <= 1'b0;
      wdReq_q <= 1'b0;
    end
    else
    begin
      devPrev_q <= devMode;
      mode_q <= mode_d;
      if (slopeWr)
      begin
        lowSlope_q <= bufData[CFG_LSM_BIT];
        flash_q <= bufData[CFG_FLASH_BIT];
      end
      wState_q <= wState_d;
      woke_q <= woke_d;
      txGate_q <= txGate_d;
      txToPrev_q <= txTimedOut;
      clampPrev_q <= busClamped;
      fault_q <= fault_d;
      wakeSt_q <= wakeSt_d;
      intPend_q <= intPend_d;
      drive_q <= drive_d;
      rx_q <= rx_d;
      restart_q <= wakeRestart;
      wdReq_q <= wdKick;
    end
  end

  assign busDriveDominant = drive_q;
  assign linRxOutput = rx_q;
  assign interruptOutN = !intPend_q;
  assign restartReq = restart_q;
  assign watchdogEnableReq = wdReq_q;
  assign lowSlope = lowSlope_q;
  assign flashMode = flash_q;
  assign transceiverMode = mode_q;
  assign wakeStatus = wakeSt_q;
  assign linFault = fault_q;

endmodule
`default_nettype wire

// File: verif/lntc_mode_ctrl_chk.sv
// concurrent checks on the mode control ports
`timescale 1ns/1ns
`default_nettype none
module lntc_mode_ctrl_chk
  import lntc_pkg::*;
#(
  parameter int unsigned TX_TO_CYCLES = 64
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // watched ports
  input wire lntc_dev_e devMode,
  input wire logic linTxInput,
  input wire logic busSupplyLow,
  input wire logic busDriveDominant,
  input wire logic linRxOutput,
  input wire logic interruptOutN,
  input wire logic restartReq,
  input wire logic wakeStatus,
  input wire logic lowSlope,
  input wire logic [1:0] transceiverMode
);
  int txLowQ;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // run length of a dominant transmit pin
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      txLowQ <= 0;
    else
      txLowQ <= linTxInput ? 0 : txLowQ + 1;
  // one cycle of slack after a mode change for the driver flop
  property p_quiet;
    $stable(transceiverMode) && transceiverMode != LM_NORMAL
      |-> !busDriveDominant;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus driven outside normal mode");
  property p_recessive;
    linTxInput [*5] |-> !busDriveDominant;
  endproperty
  a_recessive: assert property (p_recessive)
    else $error("bus driven while transmit pin recessive");
  property p_uv;
    busSupplyLow [*5] |-> !busDriveDominant;
  endproperty
  a_uv: assert property (p_uv)
    else $error("bus driven in undervoltage");
  property p_txto;
    txLowQ > TX_TO_CYCLES + 6 |-> !busDriveDominant;
  endproperty
  a_txto: assert property (p_txto)
    else $error("driver not cut after transmit time-out");
  property p_wake_rx;
    $rose(wakeStatus)
      |-> ##[0:2] (!linRxOutput && transceiverMode == LM_WAKE);
  endproperty
  a_wake_rx: assert property (p_wake_rx)
    else $error("receive output or mode wrong after wake");
  property p_restart;
    restartReq |-> interruptOutN
      && $past(devMode) inside {DM_SLEEP, DM_RESTART, DM_FAILSAFE};
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart request in wrong mode or with interrupt");
  property p_int;
    $fell(interruptOutN)
      |-> ##[0:1] (wakeStatus && devMode inside {DM_NORMAL, DM_STOP});
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt without wake status in Normal or Stop");
  property p_mode_legal;
    $changed(transceiverMode) && transceiverMode[1]
      |-> $past(devMode) inside {DM_NORMAL, DM_STOP};
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("transmit or receive mode outside Normal or Stop");
  property p_slope;
    $changed(lowSlope) |-> $past(devMode) == DM_NORMAL;
  endproperty
  a_slope: assert property (p_slope)
    else $error("slope changed outside Normal");
endmodule
bind lntc_mode_ctrl lntc_mode_ctrl_chk #(.TX_TO_CYCLES(TX_TO_CYCLES))
  lntc_mode_ctrl_chk_i (.sys_clk, .reset, .devMode, .linTxInput,
  .busSupplyLow, .busDriveDominant, .linRxOutput, .interruptOutN,
  .restartReq, .wakeStatus, .lowSlope, .transceiverMode);
`default_nettype wire

// File: verif/lntc_bus_model.sv
// single-wire bus with pull-up and a remote node
`timescale 1ns/1ns
`default_nettype none
module lntc_bus_model
#(
  parameter int LAG = 2
)
(
  // clock
  input wire logic sys_clk,
  // parties pulling the line
  input wire logic busDriveDominant,
  input wire logic remoteDom,
  // line level, high is recessive
  output logic busLevel
);
  logic [LAG-1:0] remoteQ = '0;
  // remote node reacts late, like a slow slave
  always @(posedge sys_clk)
    remoteQ <= {remoteQ[LAG-2:0], remoteDom};
  // wired-and: pull-up wins unless someone pulls low
  assign busLevel = !(busDriveDominant || remoteQ[LAG-1]);
endmodule
`default_nettype wire

// File: verif/lntc_mode_ctrl_bench.sv
// self-checking bench for the transceiver mode control
`timescale 1ns/1ns
`default_nettype none
module lntc_mode_ctrl_bench;
  import lntc_pkg::*;
  localparam int TO = 64;
  logic sys_clk = 0, reset = 1, cfgValid = 0, cfgLowSlope = 0;
  logic cfgFlash = 0, chipSelectN = 1, watchdogOnBusWake = 1;
  logic watchdogEnabled = 0, linTxInput = 1, busSupplyLow = 0;
  logic remoteDom = 0, wakeStatusClr = 0, linFaultClr = 0;
  logic [1:0] cfgMode = 2'h0;
  lntc_dev_e devMode = DM_NORMAL;
  logic cfgReady, restartReq, watchdogEnableReq, linRxOutput;
  logic interruptOutN, busLevel, busDriveDominant, lowSlope, flashMode;
  logic wakeStatus, linFault, rs, wd, expLs = 0, expFl = 0;
  logic [1:0] transceiverMode, expMode = 2'h0, r;
  int failures = 0, check_count = 0, cyc = 0;
  logic [3:0] q[$];
  lntc_mode_ctrl #(.TX_TO_CYCLES(TO), .BUS_TO_CYCLES(TO)) lntc_mode_ctrl_i
    (.sys_clk, .reset, .cfgValid, .cfgReady, .cfgMode, .cfgLowSlope,
    .cfgFlash, .chipSelectN, .devMode, .watchdogOnBusWake,
    .watchdogEnabled, .restartReq, .watchdogEnableReq, .linTxInput,
    .linRxOutput, .interruptOutN, .busLevel, .busSupplyLow,
    .busDriveDominant, .lowSlope, .flashMode, .transceiverMode,
    .wakeStatus, .wakeStatusClr, .linFault, .linFaultClr);
  lntc_bus_model #(.LAG(3)) lntc_bus_model_i
    (.sys_clk, .busDriveDominant, .remoteDom, .busLevel);
  initial
    forever #20 sys_clk = ~sys_clk;
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic push(logic [1:0] m);
    int i = 0;
    r = 2'($urandom);
    cfgValid <= 1'b1;
    {cfgMode, cfgLowSlope, cfgFlash} <= {m, r};
    q.push_back({m, r});
    tick(1);
    while (!cfgReady && i < 50)
    begin
      tick(1);
      i++;
    end
    cfgValid <= 1'b0;
    tick(1);
  endtask
  // one chip select frame applies the oldest word
  task automatic cs;
    logic [3:0] w;
    chipSelectN <= 1'b0;
    tick(2);
    chipSelectN <= 1'b1;
    tick(7);
    w = q.pop_front();
    if (w[3:2] == 2'h0 || (w[3:2] == 2'h1 && devMode != DM_FAILSAFE)
        || (w[3] && devMode inside {DM_NORMAL, DM_STOP}))
      expMode = w[3:2];
    if (devMode == DM_NORMAL)
      {expLs, expFl} = w[1:0];
    chk("mode", 4'(expMode), 4'(transceiverMode));
    chk("slope", 4'({expLs, expFl}), 4'({lowSlope, flashMode}));
    if (expMode == 2'h0)
      chk("rx", 4'h1, 4'(linRxOutput));
  endtask
  task automatic clr;
    {wakeStatusClr, linFaultClr} <= 2'h3;
    tick(1);
    {wakeStatusClr, linFaultClr} <= 2'h0;
    tick(3);
  endtask
  task automatic dom(int n);
    remoteDom <= 1'b1;
    tick(n);
    remoteDom <= 1'b0;
    {rs, wd} = 2'h0;
    repeat (12)
    begin
      tick(1);
      rs |= restartReq;
      wd |= watchdogEnableReq;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(12308));
    tick(3);
    reset <= 1'b0;
    tick(2);
    chk("reset", 4'hc, {linRxOutput, interruptOutN, busDriveDominant,
      wakeStatus});
    for (int d = 0; d < 4; d++)
    begin
      devMode <= lntc_dev_e'(d);
      tick(1);
      for (int m = 0; m < 4; m++)
      begin
        push(2'(m));
        cs();
      end
    end
    devMode <= DM_NORMAL;
    push(2'h0);
    push(2'h3);
    tick(1);
    chk("ready", 4'h0, 4'(cfgReady));
    cs();
    cs();
    // early dominant must be swallowed until enabling ends
    linTxInput <= 1'b0;
    tick(60);
    chk("early", 4'h1, {busDriveDominant, busLevel});
    linTxInput <= 1'b1;
    tick(250);
    linTxInput <= 1'b0;
    tick(10);
    chk("tx", 4'h8, {busDriveDominant, busLevel, linRxOutput, linFault});
    tick(TO);
    chk("txto", 4'h7, {busDriveDominant, linFault, transceiverMode});
    linTxInput <= 1'b1;
    tick(6);
    linTxInput <= 1'b0;
    tick(6);
    chk("txback", 4'h1, 4'(busDriveDominant));
    busSupplyLow <= 1'b1;
    remoteDom <= 1'b1;
    tick(8);
    chk("uv", 4'h7, {busDriveDominant, linRxOutput, transceiverMode});
    busSupplyLow <= 1'b0;
    remoteDom <= 1'b0;
    tick(8);
    chk("uvback", 4'h1, 4'(busDriveDominant));
    linTxInput <= 1'b1;
    clr();
    remoteDom <= 1'b1;
    tick(TO + 12);
    chk("clamp", 4'h7, {linRxOutput, linFault, transceiverMode});
    remoteDom <= 1'b0;
    clr();
    push(2'h2);
    cs();
    linTxInput <= 1'b0;
    remoteDom <= 1'b1;
    tick(10);
    chk("rxonly", 4'h0, {busDriveDominant, linRxOutput});
    {linTxInput, remoteDom} <= 2'h2;
    clr();
    for (int d = 0; d < 5; d++)
    begin
      devMode <= DM_NORMAL;
      push(2'h0);
      cs();
      dom(900);
      chk("offwake", 4'h0, 4'(wakeStatus));
      devMode <= lntc_dev_e'(d);
      watchdogOnBusWake <= 1'($urandom);
      tick(4);
      expMode = 2'h1;
      if (d < 4)
      begin
        push(2'h1);
        cs();
      end
      chk("wmode", 4'h1, 4'(transceiverMode));
      dom(100);
      chk("short", 4'h0, 4'(wakeStatus));
      dom(780 + $urandom_range(200));
      chk("wake", {2'h1, d > 1, d > 1}, {linRxOutput, wakeStatus,
        interruptOutN, rs});
      chk("wdog", 4'(d == 1 && watchdogOnBusWake), 4'(wd));
      chk("wkeep", 4'h1, {linRxOutput, transceiverMode});
      clr();
      dom(900);
      chk("stale", 4'h0, {wakeStatus, rs});
    end
    // device mode entry alone must re-arm a stale wake
    devMode <= DM_STOP;
    tick(4);
    dom(900);
    chk("rearm", 4'h2, {2'h0, wakeStatus, linRxOutput});
    print_verdict();
  end
endmodule
`default_nettype wire
